// [hdl/stc_regs.svh]
// Register offsets, field positions and the chip_select_control reset value of the serial timer and select control
`ifndef STC_REGS_SVH
`define STC_REGS_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define STC_SUPPORT_OFF   8'h00
`define STC_COUNT_OFF     8'h04
`define STC_COMPARE_OFF   8'h08
`define STC_SELECT_OFF    8'h0c
`define STC_SERIAL_OFF    8'h10
`define STC_STATUS_OFF    8'h14
`define STC_EVENT_OFF     8'h18

// ----------------------------------------
// serial_support_control fields
// ----------------------------------------
`define STC_TMR_EN_BIT    0
`define STC_TDIV_LSB      1
`define STC_TSYN_BIT      6
`define STC_TIE_BIT       7
`define STC_TFLAG_BIT     8
`define STC_SERR_BIT      11
`define STC_SEIE_BIT      12

// ----------------------------------------
// chip_select_control fields
// ----------------------------------------
`define STC_SOE_BIT       0
`define STC_SPEN_BIT      1
`define STC_SLVL_BIT      5
`define STC_CDIV_LSB      6
`define STC_HOLD_BIT      9
`define STC_SELECT_RST    16'h0020

// ----------------------------------------
// serial_control fields (own register)
// ----------------------------------------
`define STC_TXE_BIT       0
`define STC_RXE_BIT       1
`define STC_SLAVE_BIT     2
`define STC_SRST_BIT      3
`define STC_RMW_BIT       4

// ----------------------------------------
// Event register: write 1 pulses
// ----------------------------------------
`define STC_EV_XFER_BIT   0
`define STC_EV_SERR_BIT   1

`define STC_TDIV_MAX      4'h8
`define STC_CDIV_BAD      3'h7
`endif

// [hdl/stc_pkg.sv]
// Types shared by the serial timer and select control
package stc_pkg;
  typedef struct packed {
    logic [15:0] count;
    logic        flag;
    logic        start;
  } stc_timer_t;

  typedef enum logic [1:0] {
    STC_SEL_IDLE,
    STC_SEL_XFER,
    STC_SEL_HOLD
  } stc_sel_t;
endpackage

// [hdl/stc_ctrl.sv]
// Serial timer and chip-select control with an AHB-Lite register slave
`timescale 1ns/1ps
`include "stc_regs.svh"

module stc_ctrl
  import stc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        hsel,
  input  wire logic [7:0]  haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        select_pin_in,
  input  wire logic        select_error_event,
  output logic             select_out,
  output logic             select_out_en_n,
  output logic             timed_start,
  output logic             select_tick,
  output logic             status_irq,
  output logic             select_error_irq
);

  // ----------------------------------------
  // Bus slave
  // ----------------------------------------
  logic        ph_wr;
  logic        ph_rd;
  logic [7:0]  ph_addr;
  wire         take_req = hsel && hready && htrans[1];
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ph_wr   <= 1'b0;
      ph_rd   <= 1'b0;
      ph_addr <= 8'h00;
    end else begin
      ph_wr   <= take_req && hwrite;
      ph_rd   <= take_req && !hwrite;
      ph_addr <= haddr;
    end
  end
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  wire wr_sup = ph_wr && (ph_addr == `STC_SUPPORT_OFF);
  wire wr_cmp = ph_wr && (ph_addr == `STC_COMPARE_OFF);
  wire wr_sel = ph_wr && (ph_addr == `STC_SELECT_OFF);
  wire wr_ser = ph_wr && (ph_addr == `STC_SERIAL_OFF);
  wire wr_ev  = ph_wr && (ph_addr == `STC_EVENT_OFF);

  // ----------------------------------------
  // Control registers
  // ----------------------------------------
  logic        tmr_en;
  logic [3:0]  tdiv;
  logic        tsyn_raw;
  logic        tie;
  logic        seie;
  logic [15:0] compare;
  logic [2:0]  cdiv;
  logic        hold_sel;
  logic        idle_lvl;
  logic        pin_en;
  logic        out_en_raw;
  logic        transmit_enable;
  logic        receive_enable;
  logic        slave;
  logic        rmw_read;
  logic        timer_flag;
  logic        select_error_flag;

  wire       tmr_stopped = !tmr_en;
  wire       ser_idle    = !transmit_enable && !receive_enable;
  wire       soft_rst    = wr_ser && hwdata[`STC_SRST_BIT];
  wire       tsyn        = tsyn_raw && !slave;
  wire       out_en      = out_en_raw && !slave;
  wire [3:0] tdiv_wr     = hwdata[`STC_TDIV_LSB +: 4];
  wire [2:0] cdiv_wr     = hwdata[`STC_CDIV_LSB +: 3];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tmr_en   <= 1'b0;
      tdiv     <= 4'h0;
      tsyn_raw <= 1'b0;
      tie      <= 1'b0;
      seie     <= 1'b0;
    end else if (wr_sup) begin
      tmr_en <= hwdata[`STC_TMR_EN_BIT];
      tie    <= hwdata[`STC_TIE_BIT];
      seie   <= hwdata[`STC_SEIE_BIT];
      if (tmr_stopped) begin
        tsyn_raw <= hwdata[`STC_TSYN_BIT];
        if (tdiv_wr <= `STC_TDIV_MAX)
          tdiv <= tdiv_wr;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      compare <= 16'h0000;
    else if (wr_cmp && tmr_stopped)
      compare <= hwdata[15:0];
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cdiv       <= 3'h0;
      hold_sel   <= 1'b0;
      idle_lvl   <= 1'(`STC_SELECT_RST >> `STC_SLVL_BIT);
      pin_en     <= 1'b0;
      out_en_raw <= 1'b0;
    end else if (wr_sel) begin
      hold_sel <= hwdata[`STC_HOLD_BIT];
      if (ser_idle) begin
        if (cdiv_wr != `STC_CDIV_BAD)
          cdiv <= cdiv_wr;
        idle_lvl   <= hwdata[`STC_SLVL_BIT];
        pin_en     <= hwdata[`STC_SPEN_BIT];
        out_en_raw <= hwdata[`STC_SOE_BIT];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      transmit_enable      <= 1'b0;
      receive_enable      <= 1'b0;
      slave    <= 1'b0;
      rmw_read <= 1'b0;
    end else if (wr_ser) begin
      transmit_enable      <= hwdata[`STC_TXE_BIT];
      receive_enable      <= hwdata[`STC_RXE_BIT];
      slave    <= hwdata[`STC_SLAVE_BIT];
      rmw_read <= hwdata[`STC_RMW_BIT];
    end
  end

  // ----------------------------------------
  // Timer prescaler and counter
  // ----------------------------------------
  logic [7:0]  pre;
  logic [15:0] count;
  logic        tmr_en_d;
  wire         tmr_rise  = tmr_en && !tmr_en_d;
  wire [8:0]   tdiv_len  = 9'h001 << tdiv;
  wire         tick      = tmr_en && !tmr_rise &&
                           ({1'b0, pre} == 9'(tdiv_len - 9'h001));
  wire         match     = tick && (count == compare);
  stc_timer_t  next_tmr;

  always_comb begin
    next_tmr.count = count;
    next_tmr.flag  = 1'b0;
    next_tmr.start = 1'b0;
    if (tmr_rise)
      next_tmr.count = 16'h0000;
    else if (match) begin
      next_tmr.count = 16'h0000;
      next_tmr.flag  = !tsyn;
      next_tmr.start = tsyn && transmit_enable;
    end else if (tick)
      next_tmr.count = 16'(count + 16'h0001);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pre      <= 8'h00;
      count    <= 16'h0000;
      tmr_en_d <= 1'b0;
    end else begin
      tmr_en_d <= tmr_en;
      count    <= next_tmr.count;
      if (tmr_rise || tick)
        pre <= 8'h00;
      else if (tmr_en)
        pre <= 8'(pre + 8'h01);
    end
  end

  assign timed_start = next_tmr.start && !tmr_rise;

  // ----------------------------------------
  // Flags: set wins over clear
  // ----------------------------------------
  wire err_event = select_error_event && !(slave && !pin_en);
  wire clr_tflag = wr_sup && !hwdata[`STC_TFLAG_BIT];
  wire clr_serr  = wr_sup && !hwdata[`STC_SERR_BIT];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      timer_flag        <= 1'b0;
      select_error_flag <= 1'b0;
    end else begin
      if (next_tmr.flag)
        timer_flag <= 1'b1;
      else if (clr_tflag || soft_rst)
        timer_flag <= 1'b0;
      if (err_event)
        select_error_flag <= 1'b1;
      else if (clr_serr || soft_rst)
        select_error_flag <= 1'b0;
    end
  end

  assign status_irq       = timer_flag && tie;
  assign select_error_irq = select_error_flag && seie;

  // ----------------------------------------
  // Chip-select timing clock and level
  // ----------------------------------------
  logic [5:0] cpre;
  wire  [6:0] cdiv_len = 7'h01 << cdiv;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      cpre <= 6'h00;
    else if ({1'b0, cpre} == 7'(cdiv_len - 7'h01) || slave)
      cpre <= 6'h00;
    else
      cpre <= 6'(cpre + 6'h01);
  end
  // Slave timing comes from the master, so the tick stays low there
  assign select_tick = !slave && ({1'b0, cpre} == 7'(cdiv_len - 7'h01));

  // Select pin sampled through three stages
  logic [2:0] pin_sync;
  logic       pin_level;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_sync  <= 3'b000;
      pin_level <= 1'b0;
    end else begin
      pin_sync <= {pin_sync[1:0], select_pin_in};
      if (pin_sync[1] == pin_sync[2])
        pin_level <= pin_sync[2];
    end
  end

  stc_sel_t sel_st;
  stc_sel_t next_sel;
  wire      xfer_go   = timed_start || (wr_ev && hwdata[`STC_EV_XFER_BIT]);
  wire      xfer_done = wr_ev && hwdata[`STC_EV_SERR_BIT];
  wire      force_off = err_event || (soft_rst && !transmit_enable);

  always_comb begin
    next_sel = sel_st;
    case (sel_st)
      STC_SEL_IDLE: if (xfer_go && pin_en) next_sel = STC_SEL_XFER;
      STC_SEL_XFER: if (xfer_done) next_sel = hold_sel ? STC_SEL_HOLD : STC_SEL_IDLE;
      STC_SEL_HOLD: if (xfer_go) next_sel = STC_SEL_XFER;
                    else if (!hold_sel) next_sel = STC_SEL_IDLE;
      default:      next_sel = STC_SEL_IDLE;
    endcase
    if (force_off || !pin_en)
      next_sel = STC_SEL_IDLE;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      sel_st <= STC_SEL_IDLE;
    else
      sel_st <= next_sel;
  end

  wire sel_active = (sel_st != STC_SEL_IDLE);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      select_out      <= 1'b1;
      select_out_en_n <= 1'b1;
    end else begin
      select_out      <= sel_active ? !idle_lvl : idle_lvl;
      select_out_en_n <= !(out_en && pin_en);
    end
  end

  // ----------------------------------------
  // Read mux
  // ----------------------------------------
  wire        tflag_rd = timer_flag || rmw_read;
  wire        serr_rd  = select_error_flag || rmw_read;
  wire [15:0] sup_rd   = {3'h0, seie, serr_rd, 2'h0, tflag_rd, tie, tsyn,
                          1'b0, tdiv, tmr_en};
  wire [15:0] sel_rd   = {6'h00, hold_sel, cdiv, idle_lvl, 3'h0, pin_en, out_en};
  wire [15:0] ser_rd   = {11'h000, rmw_read, 1'b0, slave, receive_enable, transmit_enable};
  wire [15:0] sts_rd   = {14'h0000, pin_level, sel_active};
  logic [15:0] rd_mux;
  always_comb begin
    case (ph_addr)
      `STC_SUPPORT_OFF: rd_mux = sup_rd;
      `STC_COUNT_OFF:   rd_mux = count;
      `STC_COMPARE_OFF: rd_mux = compare;
      `STC_SELECT_OFF:  rd_mux = sel_rd;
      `STC_SERIAL_OFF:  rd_mux = ser_rd;
      `STC_STATUS_OFF:  rd_mux = sts_rd;
      default:          rd_mux = 16'h0000;
    endcase
  end
  assign hrdata = ph_rd ? {16'h0000, rd_mux} : 32'h0000_0000;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  property p_match_clears;
    @(posedge clk) disable iff (!rst_n) match && !tmr_rise |=> count == 16'h0000;
  endproperty
  a_match_clears: assert property (p_match_clears) else $error("count not cleared");

  property p_status_irq;
    @(posedge clk) disable iff (!rst_n) status_irq == (timer_flag && tie);
  endproperty
  a_status_irq: assert property (p_status_irq) else $error("status irq wrong");

  property p_flag_set;
    @(posedge clk) disable iff (!rst_n) match && !tsyn |=> timer_flag;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("flag not set");

  property p_no_flag_timed;
    @(posedge clk) disable iff (!rst_n) !timer_flag && tsyn && !wr_sup |=> !timer_flag;
  endproperty
  a_no_flag_timed: assert property (p_no_flag_timed) else $error("flag in timed mode");

  property p_start_needs_txe;
    @(posedge clk) disable iff (!rst_n) timed_start |-> transmit_enable && tsyn && match;
  endproperty
  a_start_needs_txe: assert property (p_start_needs_txe) else $error("bad start");

  property p_soft_reset;
    @(posedge clk) disable iff (!rst_n) soft_rst && !next_tmr.flag && !err_event
      |=> !timer_flag && !select_error_flag;
  endproperty
  a_soft_reset: assert property (p_soft_reset) else $error("soft reset missed");

  property p_hold_count;
    @(posedge clk) disable iff (!rst_n) !tmr_en |=> $stable(count);
  endproperty
  a_hold_count: assert property (p_hold_count) else $error("count moved");

  property p_rise_zero;
    @(posedge clk) disable iff (!rst_n) tmr_rise |=> count == 16'h0000;
  endproperty
  a_rise_zero: assert property (p_rise_zero) else $error("no restart");

  property p_slave_err;
    @(posedge clk) disable iff (!rst_n) slave && !pin_en && !select_error_flag
      |=> !select_error_flag;
  endproperty
  a_slave_err: assert property (p_slave_err) else $error("slave error set");

  property p_err_irq;
    @(posedge clk) disable iff (!rst_n) select_error_irq == (select_error_flag && seie);
  endproperty
  a_err_irq: assert property (p_err_irq) else $error("error irq wrong");

  sequence s_released;
    !sel_active ##1 select_out == idle_lvl;
  endsequence
  property p_force_off;
    @(posedge clk) disable iff (!rst_n) force_off |=> s_released;
  endproperty
  a_force_off: assert property (p_force_off) else $error("select not released");

endmodule // stc_ctrl

// [test/stc_far_end.sv]
// Far-side serial device model: chip-select pin level and select error reports
`timescale 1ns/1ps

module stc_far_end
  import stc_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic pin_req,
  input  wire logic err_req,
  output logic      pin_level,
  output logic      err_pulse
);
  // ----------------------------------------
  // Pin and error reporting
  // ----------------------------------------
  // Registered so the block never sees a change in the sampling step
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_level <= 1'b1;
      err_pulse <= 1'b0;
    end else begin
      pin_level <= pin_req;
      err_pulse <= err_req;
    end
  end
endmodule // stc_far_end

// [test/stc_ctrl_bench.sv]
// Self-checking bench of the serial timer and chip-select control
`timescale 1ns/1ps
`include "stc_regs.svh"

module stc_ctrl_bench
  import stc_pkg::*;
;
  logic        clk, rst_n, hsel, hwrite, pin_req, err_req;
  logic [7:0]  haddr;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] hwdata, hrdata, rv;
  logic        hreadyout, hresp, select_out, select_out_en_n, timed_start;
  logic        select_tick, status_irq, select_error_irq, pin_level, err_pulse;
  logic [3:0]  code;
  logic [15:0] tc;
  int          n_fail, cmp_count, g, n, seed;

  stc_ctrl stc_ctrl_inst (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .select_pin_in(pin_level),
    .select_error_event(err_pulse), .select_out(select_out),
    .select_out_en_n(select_out_en_n), .timed_start(timed_start),
    .select_tick(select_tick), .status_irq(status_irq),
    .select_error_irq(select_error_irq));

  stc_far_end stc_far_end_inst (.clk(clk), .rst_n(rst_n), .pin_req(pin_req),
    .err_req(err_req), .pin_level(pin_level), .err_pulse(err_pulse));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task results;
    if (n_fail == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      $display("unexpected t=%0t got=%h exp=%h", $time, got, exp);
      n_fail++;
    end
  endtask

  task hold_ready;
    int k;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (hreadyout !== 1'b1 && k < 16);
    if (k >= 16) begin
      n_fail++;
      results();
    end
  endtask

  // One single word transfer; read data taken where the data phase ends
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= 2'h2;
    hwrite <= w;
    hsize  <= 3'h2;
    hold_ready();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    hold_ready();
    rv = hrdata;
  endtask

  task rdchk(input logic [7:0] a, input logic [31:0] mask, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(rv & mask, exp);
  endtask

  task tick(input int c);
    repeat (c) @(negedge clk);
  endtask

  task wait_hi(input int sel, output int w);
    w = 0;
    while ((sel == 0 ? timed_start : status_irq) !== 1'b1 && w < 3000) begin
      @(negedge clk);
      w++;
    end
    if (w >= 3000) begin
      n_fail++;
      results();
    end
  endtask

  task count_starts(input int c, output int w);
    w = 0;
    repeat (c) begin
      @(negedge clk);
      if (timed_start === 1'b1) w++;
    end
  endtask

  // Keeps both flags (writing one has no effect), select error irq enabled
  function automatic logic [31:0] sup(input logic en, input logic [3:0] dv,
                                      input logic ts, input logic ie);
    sup = 32'h1900 | {27'h0, dv, en} | {24'h0, ie, ts, 6'h0};
  endfunction

  // ----------------------------------------
  // Stimulus
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  initial begin
    {hsel, hwrite, pin_req, err_req} = 4'h2;
    {haddr, htrans, hsize, hwdata} = '0;
    n_fail = 0;
    cmp_count = 0;
    seed = 32'h10353664;
    rst_n = 1'b0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    rdchk(`STC_SUPPORT_OFF, 32'hffffffff, 32'h0);
    rdchk(`STC_COUNT_OFF, 32'hffffffff, 32'h0);
    rdchk(`STC_COMPARE_OFF, 32'hffffffff, 32'h0);
    rdchk(`STC_SELECT_OFF, 32'hffffffff, `STC_SELECT_RST);
    rdchk(8'h1c, 32'hffffffff, 32'h0);
    chk(hresp, 1'b0);
    bus(1'b1, `STC_SELECT_OFF, 32'h0c3);
    bus(1'b1, `STC_SELECT_OFF, 32'h1c3);
    rdchk(`STC_SELECT_OFF, 32'hffff, 32'h0c3);
    tick(3);
    chk({select_out_en_n, select_out}, 2'b00);
    count_starts(0, n);
    n = 0;
    repeat (40) begin
      @(negedge clk);
      if (select_tick === 1'b1) n++;
    end
    chk(n, 32'd5);
    bus(1'b1, `STC_SERIAL_OFF, 32'h1);
    bus(1'b1, `STC_SELECT_OFF, 32'h0e3);
    rdchk(`STC_SELECT_OFF, 32'hffff, 32'h0c3);
    bus(1'b1, `STC_EVENT_OFF, 32'h1);
    tick(2);
    chk(select_out, 1'b1);
    bus(1'b1, `STC_EVENT_OFF, 32'h2);
    tick(2);
    chk(select_out, 1'b0);
    bus(1'b1, `STC_SELECT_OFF, 32'h2c3);
    bus(1'b1, `STC_EVENT_OFF, 32'h1);
    bus(1'b1, `STC_EVENT_OFF, 32'h2);
    tick(2);
    chk(select_out, 1'b1);
    rdchk(`STC_STATUS_OFF, 32'h3, 32'h3);
    bus(1'b1, `STC_SUPPORT_OFF, sup(1'b0, 4'h0, 1'b0, 1'b0));
    @(posedge clk) err_req <= 1'b1;
    @(posedge clk) err_req <= 1'b0;
    tick(3);
    chk({select_out, select_error_irq}, 2'b01);
    bus(1'b1, `STC_SERIAL_OFF, 32'h0);
    bus(1'b1, `STC_SUPPORT_OFF, 32'h1000);
    tick(1);
    chk(select_error_irq, 1'b0);
    bus(1'b1, `STC_SERIAL_OFF, 32'h1);
    bus(1'b1, `STC_EVENT_OFF, 32'h1);
    bus(1'b1, `STC_SERIAL_OFF, 32'h0);
    bus(1'b1, `STC_SERIAL_OFF, 32'h8);
    tick(2);
    chk(select_out, 1'b0);
    // Timed starts across every divider code with random compare values
    bus(1'b1, `STC_SERIAL_OFF, 32'h1);
    for (int i = 0; i <= 8; i++) begin
      code = 4'(i);
      tc = 16'($random(seed) & 7);
      bus(1'b1, `STC_SUPPORT_OFF, sup(1'b0, code, 1'b1, 1'b1));
      bus(1'b1, `STC_COMPARE_OFF, {16'h0, tc});
      bus(1'b1, `STC_SUPPORT_OFF, sup(1'b1, code, 1'b1, 1'b1));
      wait_hi(0, n);
      @(negedge clk);
      g = 1;
      while (timed_start !== 1'b1 && g < 3000) begin
        @(negedge clk);
        g++;
      end
      chk(g, (32'(tc) + 1) << i);
      chk(status_irq, 1'b0);
      bus(1'b1, `STC_COMPARE_OFF, 32'h0000ffff);
      rdchk(`STC_COMPARE_OFF, 32'hffffffff, {16'h0, tc});
      bus(1'b1, `STC_SUPPORT_OFF, sup(1'b0, code, 1'b1, 1'b1));
    end
    bus(1'b1, `STC_SUPPORT_OFF, sup(1'b0, 4'h9, 1'b1, 1'b1));
    rdchk(`STC_SUPPORT_OFF, 32'h1e, 32'h10);
    bus(1'b1, `STC_SERIAL_OFF, 32'h0);
    bus(1'b1, `STC_SUPPORT_OFF, sup(1'b1, 4'h0, 1'b1, 1'b1));
    count_starts(40, n);
    chk(n, 32'd0);
    bus(1'b1, `STC_SUPPORT_OFF, sup(1'b0, 4'h0, 1'b1, 1'b1));
    bus(1'b0, `STC_COUNT_OFF, 32'h0);
    g = int'(rv);
    tick(10);
    rdchk(`STC_COUNT_OFF, 32'hffffffff, 32'(g));
    // Slave: no select drive, timed mode forced off, pin-less error ignored
    bus(1'b1, `STC_SELECT_OFF, 32'h1);
    bus(1'b1, `STC_SERIAL_OFF, 32'h5);
    rdchk(`STC_SELECT_OFF, 32'h1, 32'h0);
    bus(1'b1, `STC_COMPARE_OFF, 32'h4);
    bus(1'b1, `STC_SUPPORT_OFF, sup(1'b1, 4'h0, 1'b1, 1'b1));
    wait_hi(1, n);
    chk(select_out_en_n, 1'b1);
    @(posedge clk) err_req <= 1'b1;
    @(posedge clk) err_req <= 1'b0;
    count_starts(12, n);
    chk(n, 32'h0);
    chk(select_error_irq, 1'b0);
    // Untimed flag: set, clear, read-modify-write view, soft reset
    bus(1'b1, `STC_SERIAL_OFF, 32'h0);
    bus(1'b1, `STC_SUPPORT_OFF, sup(1'b0, 4'h0, 1'b0, 1'b1));
    rdchk(`STC_SUPPORT_OFF, 32'h100, 32'h100);
    bus(1'b1, `STC_SUPPORT_OFF, 32'h1080);
    tick(1);
    chk(status_irq, 1'b0);
    bus(1'b1, `STC_SERIAL_OFF, 32'h10);
    rdchk(`STC_SUPPORT_OFF, 32'h100, 32'h100);
    bus(1'b1, `STC_SERIAL_OFF, 32'h0);
    bus(1'b1, `STC_COMPARE_OFF, 32'h0);
    bus(1'b1, `STC_SUPPORT_OFF, sup(1'b1, 4'h0, 1'b0, 1'b1));
    repeat (3) begin
      bus(1'b1, `STC_SUPPORT_OFF, 32'h1081);
      rdchk(`STC_SUPPORT_OFF, 32'h100, 32'h100);
    end
    bus(1'b1, `STC_SUPPORT_OFF, sup(1'b0, 4'h0, 1'b0, 1'b1));
    bus(1'b1, `STC_SERIAL_OFF, 32'h8);
    rdchk(`STC_SUPPORT_OFF, 32'h900, 32'h0);
    chk(status_irq, 1'b0);
    results();
  end
endmodule // stc_ctrl_bench
